// ---- pkg/pll_switch_lock_config_map.vh ----
// Register offsets, field positions, reset values and timing figures for
// the synthesizer channel configuration bank.
// Assumes a 10 MHz core clock; included by the design files only.
`ifndef PLL_SWITCH_LOCK_CONFIG_MAP_VH
`define PLL_SWITCH_LOCK_CONFIG_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_DIVIDER2_INT_UPPER_SWITCH_CTRL 8'h1f
`define OFS_DIVIDER2_NUMERATOR_BYTE1       8'h20
`define OFS_DIVIDER2_NUMERATOR_BYTE2       8'h21
`define OFS_DIVIDER2_NUMERATOR_BYTE3       8'h22
`define OFS_DIVIDER2_NUMERATOR_BYTE4       8'h23
`define OFS_DIVIDER2_DENOMINATOR_BYTE1     8'h24
`define OFS_DIVIDER2_DENOMINATOR_BYTE2     8'h25
`define OFS_DIVIDER2_DENOMINATOR_BYTE3     8'h26
`define OFS_DIVIDER2_DENOMINATOR_BYTE4     8'h27
`define OFS_OUTPUT_ENABLE_SYNC_DELAY       8'h28
`define OFS_LOCK_PHASE_WAKEUP_CTRL         8'h29
`define OFS_LOCK_THRESHOLD_CTRL            8'h2a

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define REG_RESET_VALUE 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_REVERTIVE_EN        7
`define BIT_FORCE_MANUAL        6
`define BIT_DSM_INTEGER_ONLY    5
`define FLD_INT_UPPER_MSB       4
`define FLD_SYNC_DELAY_MSB      7
`define FLD_SYNC_DELAY_LSB      6
`define FLD_OUTPUT_EN_MSB       5
`define FLD_SLOPE_MSB           7
`define FLD_SLOPE_LSB           6
`define BIT_WAIT_FOR_INPUT      5
`define BIT_FAST_LOCK_EXIT      4
`define FLD_LOCK_DELAY_MSB      3
`define FLD_LOCK_DELAY_LSB      1
`define BIT_CLEAR_THR_HIGH      0
`define BIT_CLEAR_THR_LOW       0
`define FLD_SET_THR_MSB         7
`define FLD_SET_THR_LSB         4

// ----------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ             10000000.0
`define SYNC_DELAY0_US          500.0
`define SYNC_DELAY1_MS          8.17
`define SYNC_DELAY2_MS          131.07
`define SYNC_DELAY3_SEC         2.09
`define LOCK_DELAY_EXP_BASE     26
`define LOCK_DELAY_REF_HZ       4000000.0

// ----------------------------------------------------------------------
// Frequency thresholds in units of 0.1 ppm
// ----------------------------------------------------------------------
`define THR_0P2_PPM             16'h0002
`define THR_0P4_PPM             16'h0004
`define THR_2_PPM               16'h0014
`define THR_4_PPM               16'h0028
`define THR_20_PPM              16'h00c8
`define THR_40_PPM              16'h0190
`define THR_200_PPM             16'h07d0
`define THR_400_PPM             16'h0fa0
`define THR_2000_PPM            16'h4e20
`define THR_4000_PPM            16'h9c40

`endif

// ---- hdl/delay_timer.v ----
// Reloadable down-counter that reports when a programmed delay has passed.
// Assumes a load pulse and count from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module delay_timer (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        load,
  input  wire [27:0] count,
  input  wire        hold,
  output wire        expired
);

  reg  [27:0] remain_q;
  reg         armed_q;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Hold clears the timer so a broken wait never reports expiry.
  always @(posedge ref_clk) begin
    if (srst || hold) begin
      remain_q <= 28'h0000000;
      armed_q  <= 1'b0;
    end else if (load) begin
      remain_q <= count;
      armed_q  <= 1'b1;
    end else if (remain_q != 28'h0000000) begin
      remain_q <= remain_q - 28'h0000001;
    end
  end

  assign expired = armed_q && (remain_q == 28'h0000000) && !load;

endmodule // delay_timer

`default_nettype wire

// ---- hdl/pll_switch_lock_config_bank.v ----
// Configuration bank for one synthesizer channel: second feedback divider,
// input clock switching, power-up sequencing and loss-of-lock detection.
// Assumes a byte register port driven by the serial host port decoder on
// ref_clk; clock-valid and manual select levels arrive from pins.
`timescale 1ns/1ps
`default_nettype none
`include "pll_switch_lock_config_map.vh"

module pll_switch_lock_config_bank #(
  parameter [27:0] LOCK_DELAY_BASE_CYCLES = 28'd167772160,
  parameter [27:0] SYNC_DELAY0_CYCLES     = 28'd5000,
  parameter [27:0] SYNC_DELAY1_CYCLES     = 28'd81700,
  parameter [27:0] SYNC_DELAY2_CYCLES     = 28'd1310700,
  parameter [27:0] SYNC_DELAY3_CYCLES     = 28'd20900000
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] divider_int_lower,
  input  wire [3:0]  input_clk_valid,
  input  wire [1:0]  manual_select_pins,
  input  wire        pin_select_enable,
  input  wire [1:0]  preferred_input,
  input  wire [15:0] freq_offset,
  input  wire        freq_offset_valid,
  output wire [20:0] second_feedback_divider_int,
  output wire [31:0] second_feedback_divider_num,
  output wire [31:0] second_feedback_divider_den,
  output wire        dsm_integer_only,
  output wire [1:0]  phase_slope_code,
  output reg  [1:0]  active_input,
  output reg         holdover,
  output reg         fast_lock,
  output reg  [5:0]  output_enable,
  output reg         sequence_done,
  output reg         lock_loss_flag
);

  // ----------------------------------------------------------------------
  // Local definitions
  // ----------------------------------------------------------------------
  localparam [1:0] SEQ_WAIT_INPUT = 2'b00;
  localparam [1:0] SEQ_DELAY      = 2'b01;
  localparam [1:0] SEQ_RUN        = 2'b10;

  // Real figures show how the default counts above are formed.
  localparam real SYNC0_REAL = `SYNC_DELAY0_US * `CLK_FREQ_HZ / 1.0e6;
  localparam real SYNC1_REAL = `SYNC_DELAY1_MS * `CLK_FREQ_HZ / 1.0e3;
  localparam real SYNC2_REAL = `SYNC_DELAY2_MS * `CLK_FREQ_HZ / 1.0e3;
  localparam real SYNC3_REAL = `SYNC_DELAY3_SEC * `CLK_FREQ_HZ;
  localparam real LOCK_REAL  = (2.0 ** `LOCK_DELAY_EXP_BASE) *
                               `CLK_FREQ_HZ / `LOCK_DELAY_REF_HZ;

  reg  [7:0]  switch_ctrl_q;
  reg  [7:0]  num_q [0:3];
  reg  [7:0]  den_q [0:3];
  reg  [7:0]  out_en_q;
  reg  [7:0]  lock_ctrl_q;
  reg  [7:0]  thr_ctrl_q;
  reg  [3:0]  valid_meta_q;
  reg  [3:0]  valid_q;
  reg  [1:0]  pins_meta_q;
  reg  [1:0]  pins_q;
  reg  [1:0]  seq_state_q;
  reg         seq_load_q;
  reg         wait_load_q;
  reg  [15:0] set_thr;
  reg  [15:0] clr_thr;
  reg  [27:0] sync_count;
  reg  [1:0]  first_valid;
  reg         any_valid;
  reg  [7:0]  rdata_d;
  wire [1:0]  clr_code;
  wire [2:0]  delay_code;
  wire [27:0] lock_count;
  wire        sync_expired;
  wire        lock_expired;
  wire        below_clear;
  wire        above_set;
  reg         lock_busy_q;
  integer     i;
  integer     j;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      switch_ctrl_q <= `REG_RESET_VALUE;
      out_en_q      <= `REG_RESET_VALUE;
      lock_ctrl_q   <= `REG_RESET_VALUE;
      thr_ctrl_q    <= `REG_RESET_VALUE;
      for (i = 0; i < 4; i = i + 1) begin
        num_q[i] <= `REG_RESET_VALUE;
        den_q[i] <= `REG_RESET_VALUE;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_DIVIDER2_INT_UPPER_SWITCH_CTRL: switch_ctrl_q <= reg_wdata;
        `OFS_DIVIDER2_NUMERATOR_BYTE1:   num_q[0] <= reg_wdata;
        `OFS_DIVIDER2_NUMERATOR_BYTE2:   num_q[1] <= reg_wdata;
        `OFS_DIVIDER2_NUMERATOR_BYTE3:   num_q[2] <= reg_wdata;
        `OFS_DIVIDER2_NUMERATOR_BYTE4:   num_q[3] <= reg_wdata;
        `OFS_DIVIDER2_DENOMINATOR_BYTE1: den_q[0] <= reg_wdata;
        `OFS_DIVIDER2_DENOMINATOR_BYTE2: den_q[1] <= reg_wdata;
        `OFS_DIVIDER2_DENOMINATOR_BYTE3: den_q[2] <= reg_wdata;
        `OFS_DIVIDER2_DENOMINATOR_BYTE4: den_q[3] <= reg_wdata;
        `OFS_OUTPUT_ENABLE_SYNC_DELAY:   out_en_q <= reg_wdata;
        `OFS_LOCK_PHASE_WAKEUP_CTRL:     lock_ctrl_q <= reg_wdata;
        `OFS_LOCK_THRESHOLD_CTRL:        thr_ctrl_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  // Unmapped offsets read as zero so the host decoder needs no error path.
  always @* begin
    case (reg_addr)
      `OFS_DIVIDER2_INT_UPPER_SWITCH_CTRL: rdata_d = switch_ctrl_q;
      `OFS_DIVIDER2_NUMERATOR_BYTE1:   rdata_d = num_q[0];
      `OFS_DIVIDER2_NUMERATOR_BYTE2:   rdata_d = num_q[1];
      `OFS_DIVIDER2_NUMERATOR_BYTE3:   rdata_d = num_q[2];
      `OFS_DIVIDER2_NUMERATOR_BYTE4:   rdata_d = num_q[3];
      `OFS_DIVIDER2_DENOMINATOR_BYTE1: rdata_d = den_q[0];
      `OFS_DIVIDER2_DENOMINATOR_BYTE2: rdata_d = den_q[1];
      `OFS_DIVIDER2_DENOMINATOR_BYTE3: rdata_d = den_q[2];
      `OFS_DIVIDER2_DENOMINATOR_BYTE4: rdata_d = den_q[3];
      `OFS_OUTPUT_ENABLE_SYNC_DELAY:   rdata_d = out_en_q;
      `OFS_LOCK_PHASE_WAKEUP_CTRL:     rdata_d = lock_ctrl_q;
      `OFS_LOCK_THRESHOLD_CTRL:        rdata_d = thr_ctrl_q;
      default:                         rdata_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Divider words
  // ----------------------------------------------------------------------
  assign second_feedback_divider_int =
    {switch_ctrl_q[`FLD_INT_UPPER_MSB:0], divider_int_lower};
  assign dsm_integer_only = switch_ctrl_q[`BIT_DSM_INTEGER_ONLY];
  // The fraction is zeroed, not just flagged, so the modulator stays quiet.
  assign second_feedback_divider_num = dsm_integer_only ? 32'h00000000 :
    {num_q[3], num_q[2], num_q[1], num_q[0]};
  assign second_feedback_divider_den =
    {den_q[3], den_q[2], den_q[1], den_q[0]};
  assign phase_slope_code =
    lock_ctrl_q[`FLD_SLOPE_MSB:`FLD_SLOPE_LSB];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      valid_meta_q <= 4'h0;
      valid_q      <= 4'h0;
      pins_meta_q  <= 2'h0;
      pins_q       <= 2'h0;
    end else begin
      valid_meta_q <= input_clk_valid;
      valid_q      <= valid_meta_q;
      pins_meta_q  <= manual_select_pins;
      pins_q       <= pins_meta_q;
    end
  end

  always @* begin
    any_valid   = |valid_q;
    first_valid = 2'h0;
    for (j = 3; j >= 0; j = j - 1) begin
      if (valid_q[j]) begin
        first_valid = j[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input clock selection
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      active_input <= 2'h0;
      holdover     <= 1'b0;
      fast_lock    <= 1'b0;
    end else begin
      if (switch_ctrl_q[`BIT_FORCE_MANUAL]) begin
        if (pin_select_enable) begin
          active_input <= pins_q;
        end else begin
          active_input <= preferred_input;
        end
      end else if (switch_ctrl_q[`BIT_REVERTIVE_EN] &&
                   valid_q[preferred_input]) begin
        active_input <= preferred_input;
      end else if (!valid_q[active_input] && any_valid) begin
        active_input <= first_valid;
      end
      holdover <= !any_valid;
      // Fast lock lasts from holdover exit until the loop reports lock.
      if (holdover && any_valid && lock_ctrl_q[`BIT_FAST_LOCK_EXIT]) begin
        fast_lock <= 1'b1;
      end else if (!lock_loss_flag && freq_offset_valid) begin
        fast_lock <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power-up sequence
  // ----------------------------------------------------------------------
  always @* begin
    case (out_en_q[`FLD_SYNC_DELAY_MSB:`FLD_SYNC_DELAY_LSB])
      2'h0:    sync_count = SYNC_DELAY0_CYCLES;
      2'h1:    sync_count = SYNC_DELAY1_CYCLES;
      2'h2:    sync_count = SYNC_DELAY2_CYCLES;
      default: sync_count = SYNC_DELAY3_CYCLES;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      seq_state_q   <= SEQ_WAIT_INPUT;
      seq_load_q    <= 1'b0;
      sequence_done <= 1'b0;
      output_enable <= 6'h00;
    end else begin
      seq_load_q <= 1'b0;
      case (seq_state_q)
        SEQ_WAIT_INPUT: begin
          if (any_valid || !lock_ctrl_q[`BIT_WAIT_FOR_INPUT]) begin
            seq_state_q <= SEQ_DELAY;
            seq_load_q  <= 1'b1;
          end
        end
        SEQ_DELAY: begin
          if (sync_expired) begin
            seq_state_q   <= SEQ_RUN;
            sequence_done <= 1'b1;
          end
        end
        SEQ_RUN: begin
          sequence_done <= 1'b1;
        end
        default: begin
          seq_state_q <= SEQ_WAIT_INPUT;
        end
      endcase
      // Outputs stay off until the sync delay has run out.
      output_enable <= sequence_done ?
                       out_en_q[`FLD_OUTPUT_EN_MSB:0] : 6'h00;
    end
  end

  delay_timer sync_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (seq_load_q),
    .count   (sync_count),
    .hold    (1'b0),
    .expired (sync_expired)
  );

  // ----------------------------------------------------------------------
  // Lock thresholds
  // ----------------------------------------------------------------------
  assign clr_code = {lock_ctrl_q[`BIT_CLEAR_THR_HIGH],
                     thr_ctrl_q[`BIT_CLEAR_THR_LOW]};
  assign delay_code = lock_ctrl_q[`FLD_LOCK_DELAY_MSB:`FLD_LOCK_DELAY_LSB];

  always @* begin
    case (clr_code)
      2'h0:    clr_thr = `THR_0P2_PPM;
      2'h1:    clr_thr = `THR_0P4_PPM;
      2'h2:    clr_thr = `THR_2_PPM;
      default: clr_thr = `THR_200_PPM;
    endcase
    case (thr_ctrl_q[`FLD_SET_THR_MSB:`FLD_SET_THR_LSB])
      4'h0:    set_thr = `THR_0P2_PPM;
      4'h1:    set_thr = `THR_0P4_PPM;
      4'h2:    set_thr = `THR_2_PPM;
      4'h3:    set_thr = `THR_4_PPM;
      4'h4:    set_thr = `THR_20_PPM;
      4'h5:    set_thr = `THR_40_PPM;
      4'h6:    set_thr = `THR_200_PPM;
      4'h7:    set_thr = `THR_400_PPM;
      4'h8:    set_thr = `THR_2000_PPM;
      4'h9:    set_thr = `THR_4000_PPM;
      default: set_thr = `THR_0P2_PPM;
    endcase
  end

  // Each code step divides the wait by four.
  assign lock_count = LOCK_DELAY_BASE_CYCLES >> {delay_code, 1'b0};

  // ----------------------------------------------------------------------
  // Loss-of-lock flag
  // ----------------------------------------------------------------------
  assign above_set   = freq_offset_valid && (freq_offset > set_thr);
  assign below_clear = freq_offset_valid && (freq_offset <= clr_thr);

  always @(posedge ref_clk) begin
    if (srst) begin
      lock_loss_flag <= 1'b0;
      wait_load_q    <= 1'b0;
    end else begin
      wait_load_q <= 1'b0;
      if (above_set) begin
        lock_loss_flag <= 1'b1;
      // A sample above the clear level on the expiry edge keeps the flag.
      end else if (lock_loss_flag && lock_expired &&
                   (below_clear || !freq_offset_valid)) begin
        lock_loss_flag <= 1'b0;
      end
      // The wait restarts on any sample above the clear level.
      if (freq_offset_valid && !below_clear) begin
        wait_load_q <= 1'b1;
      end
    end
  end

  delay_timer lock_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (wait_load_q || (lock_loss_flag && !lock_busy_q)),
    .count   (lock_count),
    .hold    (!lock_loss_flag),
    .expired (lock_expired)
  );

  always @(posedge ref_clk) begin
    if (srst || !lock_loss_flag) begin
      lock_busy_q <= 1'b0;
    end else begin
      lock_busy_q <= 1'b1;
    end
  end

endmodule // pll_switch_lock_config_bank

`default_nettype wire

// ---- verif/pll_switch_lock_config_bank_props.sv ----
// Port checker for the channel configuration bank.
// Assumes binding to the bank; one clock, synchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module pll_switch_lock_config_bank_props (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] freq_offset,
  input wire logic        freq_offset_valid,
  input wire logic [31:0] second_feedback_divider_num,
  input wire logic        dsm_integer_only,
  input wire logic [1:0]  phase_slope_code,
  input wire logic [5:0]  output_enable,
  input wire logic        sequence_done,
  input wire logic        lock_loss_flag
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_num_zero;
    dsm_integer_only |-> second_feedback_divider_num == 32'h0;
  endproperty
  a_num_zero: assert property (p_num_zero)
    else $error("fraction not suppressed");
  property p_dsm_write;
    reg_wr && reg_addr == 8'h1f && reg_wdata[5] |=> dsm_integer_only;
  endproperty
  a_dsm_write: assert property (p_dsm_write)
    else $error("integer mode not taken");
  property p_slope;
    reg_wr && reg_addr == 8'h29
      |=> {phase_slope_code, 6'h0} == ($past(reg_wdata) & 8'hc0);
  endproperty
  a_slope: assert property (p_slope)
    else $error("slope code wrong");
  property p_oe_gate;
    !$past(sequence_done) |-> output_enable == 6'h0;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("outputs enabled early");
  property p_done_hold;
    sequence_done |=> sequence_done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("sequence done dropped");
  property p_lock_set;
    freq_offset_valid && freq_offset > 16'h9c40 |=> lock_loss_flag;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock loss not set");
  property p_lock_stay;
    lock_loss_flag && freq_offset_valid && freq_offset > 16'h07d0
      |=> lock_loss_flag [*2];
  endproperty
  a_lock_stay: assert property (p_lock_stay)
    else $error("lock loss cleared too soon");
  property p_unmapped;
    reg_rd && (reg_addr < 8'h1f || reg_addr > 8'h2a) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed");
  c_lock: cover property ($rose(lock_loss_flag));
  c_clear: cover property ($fell(lock_loss_flag));
  c_done: cover property ($rose(sequence_done));
endmodule // pll_switch_lock_config_bank_props

bind pll_switch_lock_config_bank pll_switch_lock_config_bank_props u_props (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .freq_offset(freq_offset),
  .freq_offset_valid(freq_offset_valid),
  .second_feedback_divider_num(second_feedback_divider_num),
  .dsm_integer_only(dsm_integer_only), .phase_slope_code(phase_slope_code),
  .output_enable(output_enable), .sequence_done(sequence_done),
  .lock_loss_flag(lock_loss_flag)
);
`default_nettype wire

// ---- verif/pll_switch_lock_config_bank_tb.sv ----
// Self-checking bench for the channel configuration bank.
// Assumes short sim delays: lock base 256, sync code 0 of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module pll_switch_lock_config_bank_tb;
  logic        ref_clk, srst, reg_wr, reg_rd, pin_select_enable;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] divider_int_lower, freq_offset;
  logic [3:0]  input_clk_valid;
  logic [1:0]  manual_select_pins, preferred_input, phase_slope_code;
  logic [1:0]  active_input;
  logic        freq_offset_valid, dsm_integer_only, holdover, fast_lock;
  logic [20:0] div_int;
  logic [31:0] div_num, div_den;
  logic [5:0]  output_enable;
  logic        sequence_done, lock_loss_flag;
  int          bad_count, comparisons, cycles;
  logic [15:0] thr_tab [16] = '{16'h2, 16'h4, 16'h14, 16'h28, 16'hc8,
    16'h190, 16'h7d0, 16'hfa0, 16'h4e20, 16'h9c40, 16'h2, 16'h2, 16'h2,
    16'h2, 16'h2, 16'h2};
  logic [15:0] clr_tab [4] = '{16'h2, 16'h4, 16'h14, 16'h7d0};

  pll_switch_lock_config_bank #(
    .LOCK_DELAY_BASE_CYCLES(28'd256), .SYNC_DELAY0_CYCLES(28'd20),
    .SYNC_DELAY1_CYCLES(28'd30), .SYNC_DELAY2_CYCLES(28'd40),
    .SYNC_DELAY3_CYCLES(28'd50)
  ) u_dut (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .divider_int_lower(divider_int_lower),
    .input_clk_valid(input_clk_valid),
    .manual_select_pins(manual_select_pins),
    .pin_select_enable(pin_select_enable), .preferred_input(preferred_input),
    .freq_offset(freq_offset), .freq_offset_valid(freq_offset_valid),
    .second_feedback_divider_int(div_int),
    .second_feedback_divider_num(div_num),
    .second_feedback_divider_den(div_den),
    .dsm_integer_only(dsm_integer_only), .phase_slope_code(phase_slope_code),
    .active_input(active_input), .holdover(holdover), .fast_lock(fast_lock),
    .output_enable(output_enable), .sequence_done(sequence_done),
    .lock_loss_flag(lock_loss_flag)
  );

  // ----
  // Shared tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    d = reg_rdata;
    reg_rd = 1'b0;
    tick(1);
  endtask
  // Holds valid across n edges so the strobe is never lowered and raised
  // again in the same time step.
  task automatic samples(input logic [15:0] v, input int n);
    freq_offset = v;
    freq_offset_valid = 1'b1;
    tick(n);
    freq_offset_valid = 1'b0;
    tick(1);
  endtask
  task automatic wait_lock(input logic v, input int lim, output int n);
    n = 0;
    while (lock_loss_flag !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[3:0], ~a[3:0]};
  endfunction

  // ----
  // Scenarios
  // ----
  task automatic t_sequence;
    int n;
    wr(8'h28, 8'h15);
    check("enables gated", output_enable, 6'h0);
    n = 1;
    while (sequence_done !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    check("sync delay", 32'(n >= 18 && n <= 26), 1);
    tick(1);
    check("enables", output_enable, 6'h15);
    $display("test sequence done");
  endtask
  task automatic t_reset_values;
    logic [7:0] d;
    for (int a = 8'h1e; a <= 8'h2b; a++) begin
      rd(a[7:0], d);
      check("reset value", d, (a == 8'h28) ? 8'h15 : 8'h00);
    end
    $display("test reset_values done");
  endtask
  task automatic t_readback;
    logic [7:0] d;
    for (int a = 8'h1f; a <= 8'h2a; a++) wr(a[7:0], pat(a[7:0]));
    wr(8'h2b, 8'hff);
    check("int", div_int, {pat(8'h1f), 16'hbeef} & 21'h1fffff);
    check("num off", div_num, 32'h0);
    check("den", div_den, 32'h7869_5a4b);
    check("slope", phase_slope_code, 2'h2);
    wr(8'h1f, 8'h0f);
    check("dsm", dsm_integer_only, 1'b0);
    check("num", div_num, 32'h3c2d_1e0f);
    for (int a = 8'h20; a <= 8'h2b; a++) begin
      rd(a[7:0], d);
      check("readback", d, (a == 8'h2b) ? 8'h00 : pat(a[7:0]));
    end
    $display("test readback done");
  endtask
  task automatic t_switching;
    input_clk_valid = 4'hf;
    preferred_input = 2'h1;
    pin_select_enable = 1'b1;
    manual_select_pins = 2'h2;
    wr(8'h1f, 8'h40);
    tick(5);
    check("manual pins", active_input, 2'h2);
    pin_select_enable = 1'b0;
    tick(5);
    check("manual reg", active_input, 2'h1);
    wr(8'h1f, 8'h80);
    preferred_input = 2'h3;
    tick(5);
    check("revert", active_input, 2'h3);
    wr(8'h1f, 8'h00);
    preferred_input = 2'h0;
    tick(5);
    check("no revert", active_input, 2'h3);
    input_clk_valid = 4'h6;
    tick(6);
    check("auto move", active_input, 2'h1);
    $display("test switching done");
  endtask
  task automatic t_holdover;
    int n;
    wr(8'h29, 8'h10);
    samples(16'h0, 1);
    check("fast lock idle", fast_lock, 1'b0);
    input_clk_valid = 4'h0;
    tick(6);
    check("holdover", holdover, 1'b1);
    input_clk_valid = 4'h4;
    n = 0;
    while (holdover !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    check("fast lock", fast_lock, 1'b1);
    samples(16'h0, 1);
    tick(1);
    check("fast lock off", fast_lock, 1'b0);
    $display("test holdover done");
  endtask
  task automatic t_set_thresholds;
    int n;
    wr(8'h29, 8'h0e);
    for (int c = 0; c < 16; c++) begin
      wr(8'h2a, {c[3:0], 4'h0});
      samples(thr_tab[c], 1);
      check("at set level", lock_loss_flag, 1'b0);
      samples(thr_tab[c] + 16'h1, 1);
      check("above set level", lock_loss_flag, 1'b1);
      wait_lock(1'b0, 40, n);
      check("released", lock_loss_flag, 1'b0);
    end
    $display("test set_thresholds done");
  endtask
  task automatic t_delay;
    int n;
    int cnt;
    wr(8'h2a, 8'h00);
    for (int c = 0; c < 8; c++) begin
      cnt = 256 >> (2 * c);
      wr(8'h29, {4'h0, c[2:0], 1'b0});
      samples(16'hffff, 1);
      wait_lock(1'b0, 300, n);
      check("loss delay", 32'(n >= cnt && n <= cnt + 4), 1);
    end
    $display("test delay done");
  endtask
  task automatic t_clear_thresholds;
    for (int k = 0; k < 4; k++) begin
      wr(8'h29, {7'h03, k[1]});
      wr(8'h2a, {7'h48, k[0]});
      samples(16'hffff, 1);
      samples(clr_tab[k] + 16'h1, 70);
      check("above clear", lock_loss_flag, 1'b1);
      samples(clr_tab[k], 70);
      check("at clear", lock_loss_flag, 1'b0);
    end
    $display("test clear_thresholds done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // A hang in any wait loop is cut short well past the expected length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("timeout reached");
      results();
    end
  end
  initial begin
    logic [7:0] d;
    {reg_wr, reg_rd, pin_select_enable, freq_offset_valid} = 4'h0;
    {reg_addr, reg_wdata, freq_offset} = 32'h0;
    {manual_select_pins, preferred_input, input_clk_valid} = 8'h0;
    divider_int_lower = 16'hbeef;
    srst = 1'b1;
    tick(12);
    srst = 1'b0;
    t_sequence();
    t_reset_values();
    t_readback();
    t_switching();
    t_holdover();
    t_set_thresholds();
    t_delay();
    t_clear_thresholds();
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    rd(8'h20, d);
    check("second reset", d, 8'h00);
    results();
  end
endmodule // pll_switch_lock_config_bank_tb
`default_nettype wire
